// *** rtl/ssr_security_route.v ***
`timescale 1ns/1ps
`include "ssr_regs.vh"

// per-interface status, interrupt and translation-request port
module ssr_iface_state (
    input  wire       clk,
    input  wire       resetn,
    input  wire [3:0] setBits,
    input  wire [3:0] clrBits,
    input  wire [1:0] irqEn,
    input  wire       ifaceEn,
    input  wire       xlatReq,
    input  wire       xlatNsIn,
    output reg  [3:0] status_q,
    output wire       irq,
    output reg        xlatDone_q,
    output reg        xlatFault_q,
    output reg        xlatNs_q
);
    // set beats clear in the same cycle
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_q <= `SSR_ST_RST;
        end else begin
            status_q <= (status_q & ~clrBits) | setBits;
        end
    end

    // level interrupt, gated by this interface's enables only
    assign irq = (irqEn[`SSR_IRQ_EVT] & status_q[`SSR_ST_EVTPEND])
               | (irqEn[`SSR_IRQ_ERR] & |(status_q & `SSR_ST_ERRMASK));

    // translation request answered next cycle; disabled interface faults it
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            xlatDone_q  <= 1'b0;
            xlatFault_q <= 1'b0;
            xlatNs_q    <= 1'b1;
        end else begin
            xlatDone_q  <= xlatReq;
            xlatFault_q <= xlatReq & ~ifaceEn;
            xlatNs_q    <= xlatNsIn;
        end
    end
endmodule

module ssr_security_route #(
    parameter SECURITY_SUPPORT = 1
) (
    input  wire        clk,
    input  wire        resetn,
    // wishbone classic slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // incoming client transaction with its entry fields
    input  wire        txnValid,
    input  wire [7:0]  txnStreamId,
    input  wire        txnSecureStreamFlag,
    input  wire        txnIncomingSecurityAttribute,
    input  wire        txnInstrFetch,
    input  wire        entBypass,
    input  wire        entOverrideEn,
    input  wire        entOverrideNs,
    input  wire        entStage1,
    input  wire        entRegimeEl3,
    input  wire        walkFromSecure,
    input  wire        descNs,
    input  wire        tableLevelSecurityBit,
    // translation result
    output reg         outValid,
    output reg         outAbort,
    output reg         outNonSecureAttribute,
    output reg  [1:0]  outRegimeTag,
    output reg         outAsidValid,
    // stream table fetch request
    output reg         fetchValid,
    output reg         fetchSecureTable,
    output reg  [7:0]  fetchIndex,
    output reg         fetchNonSecureAttribute,
    // context descriptor fetch
    input  wire        ctxReq,
    input  wire        ctxSecureStream,
    output reg         ctxValid,
    output reg         ctxNonSecureAttribute,
    output reg         ctxViaStage2,
    // events
    input  wire        evtValid,
    input  wire        evtSecureStream,
    input  wire [7:0]  evtCode,
    input  wire        evtNsFull,
    input  wire        evtSFull,
    output reg         evtNsWrite,
    output reg         evtSWrite,
    output reg  [7:0]  evtData,
    output reg         evtNonSecureAttribute,
    // commands from the two queues
    input  wire        cmdNsValid,
    input  wire [7:0]  cmdNsStreamId,
    input  wire        cmdSValid,
    input  wire [7:0]  cmdSStreamId,
    input  wire        cmdSSecureStreamFlag,
    output reg         cmdOutValid,
    output reg  [7:0]  cmdOutStreamId,
    output reg         cmdOutSecureTarget,
    output reg         cmdOutNonSecureAttribute,
    // queue error reports
    input  wire        cmdNsError,
    input  wire        cmdSError,
    input  wire        queueNsAbort,
    input  wire        queueSAbort,
    // translation-request ports
    input  wire        xlatNsReq,
    input  wire        xlatSReq,
    input  wire        xlatSNsIn,
    output wire        xlatNsDone,
    output wire        xlatNsFault,
    output wire        xlatNsResultNs,
    output wire        xlatSDone,
    output wire        xlatSFault,
    output wire        xlatSResultNs,
    // interrupts
    output wire        irqNs,
    output wire        irqS
);
    wire        secOk = (SECURITY_SUPPORT != 0);
    reg  [1:0]  nsCtrl_q;
    reg  [5:0]  sCtrl_q;
    reg  [1:0]  nsIrqEn_q;
    reg  [1:0]  sIrqEn_q;
    wire [3:0]  nsStatus;
    wire [3:0]  sStatus;
    reg  [3:0]  nsSet;
    reg  [3:0]  sSet;
    reg  [3:0]  nsClr;
    reg  [3:0]  sClr;
    reg  [31:0] rdData;
    wire        req     = wb_cyc_i & wb_stb_i;
    wire        wrFire  = req & wb_we_i & wb_ack_o & wb_sel_i[0];
    wire        nsEn    = nsCtrl_q[`SSR_CTRL_EN];
    wire        sEn     = sCtrl_q[`SSR_CTRL_EN] & secOk;
    wire        s2En    = sCtrl_q[`SSR_CTRL_S2EN] & secOk;

    // ack one cycle after request, dropped the cycle after
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
            wb_dat_o <= rdData;
        end
    end

    // read mux; secure registers read zero without security support
    always @* begin
        rdData = 32'h0000_0000;
        case (wb_adr_i)
            `SSR_NS_CTRL:   rdData[1:0] = nsCtrl_q;
            `SSR_NS_IRQEN:  rdData[1:0] = nsIrqEn_q;
            `SSR_NS_STATUS: rdData[3:0] = nsStatus;
            `SSR_S_CTRL:    rdData[5:0] = secOk ? sCtrl_q : 6'h00;
            `SSR_S_IRQEN:   rdData[1:0] = secOk ? sIrqEn_q : 2'h0;
            `SSR_S_STATUS:  rdData[3:0] = secOk ? sStatus : 4'h0;
            `SSR_INFO:      rdData[0]   = secOk;
            default:        rdData = 32'h0000_0000;
        endcase
    end

    // writes land at the ack edge; secure writes ignored without support
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            nsCtrl_q  <= 2'h0;
            sCtrl_q   <= `SSR_CTRL_RST;
            nsIrqEn_q <= `SSR_IRQEN_RST;
            sIrqEn_q  <= `SSR_IRQEN_RST;
        end else if (wrFire) begin
            if (wb_adr_i == `SSR_NS_CTRL)
                nsCtrl_q <= wb_dat_i[1:0];
            if (wb_adr_i == `SSR_NS_IRQEN)
                nsIrqEn_q <= wb_dat_i[1:0];
            if (wb_adr_i == `SSR_S_CTRL && secOk)
                sCtrl_q <= wb_dat_i[5:0];
            if (wb_adr_i == `SSR_S_IRQEN && secOk)
                sIrqEn_q <= wb_dat_i[1:0];
        end
    end

    // write-one-to-clear strobes per status register
    always @* begin
        nsClr = 4'h0;
        sClr  = 4'h0;
        if (wrFire && wb_adr_i == `SSR_NS_STATUS)
            nsClr = wb_dat_i[3:0];
        if (wrFire && wb_adr_i == `SSR_S_STATUS)
            sClr = wb_dat_i[3:0];
    end

    // event routing; a full queue only flags overflow on its own side
    wire evtSec = evtSecureStream & secOk;
    always @* begin
        nsSet = 4'h0;
        sSet  = 4'h0;
        nsSet[`SSR_ST_CMDERR]  = cmdNsError;
        nsSet[`SSR_ST_QABORT]  = queueNsAbort;
        nsSet[`SSR_ST_OVFL]    = evtValid & ~evtSec & evtNsFull;
        nsSet[`SSR_ST_EVTPEND] = evtValid & ~evtSec & ~evtNsFull;
        sSet[`SSR_ST_CMDERR]   = cmdSError & secOk;
        sSet[`SSR_ST_QABORT]   = queueSAbort & secOk;
        sSet[`SSR_ST_OVFL]     = evtValid & evtSec & evtSFull;
        sSet[`SSR_ST_EVTPEND]  = evtValid & evtSec & ~evtSFull;
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            evtNsWrite            <= 1'b0;
            evtSWrite             <= 1'b0;
            evtData               <= 8'h00;
            evtNonSecureAttribute <= 1'b1;
        end else begin
            evtNsWrite            <= evtValid & ~evtSec & ~evtNsFull;
            evtSWrite             <= evtValid & evtSec & ~evtSFull;
            evtData               <= evtCode;
            evtNonSecureAttribute <= ~evtSec;
        end
    end

    // command issue; secure queue wins when both present, ns held off by caller
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmdOutValid              <= 1'b0;
            cmdOutStreamId           <= 8'h00;
            cmdOutSecureTarget       <= 1'b0;
            cmdOutNonSecureAttribute <= 1'b1;
        end else if (cmdSValid && secOk) begin
            cmdOutValid              <= 1'b1;
            cmdOutStreamId           <= cmdSStreamId;
            cmdOutSecureTarget       <= cmdSSecureStreamFlag;
            cmdOutNonSecureAttribute <= 1'b0;
        end else begin
            cmdOutValid              <= cmdNsValid;
            cmdOutStreamId           <= cmdNsStreamId;
            cmdOutSecureTarget       <= 1'b0;
            cmdOutNonSecureAttribute <= 1'b1;
        end
    end

    // attribute decision for one transaction
    reg txSec;
    reg txEn;
    reg txNs;
    reg txAbort;
    always @* begin
        txSec   = txnSecureStreamFlag & secOk;
        txEn    = txSec ? sEn : nsEn;
        txNs    = 1'b1;
        txAbort = 1'b0;
        if (!txSec) begin
            txNs    = 1'b1;
            txAbort = ~nsEn & nsCtrl_q[`SSR_CTRL_ABORT];
        end else if (!txEn) begin
            txAbort = sCtrl_q[`SSR_CTRL_ABORT];
            txNs    = sCtrl_q[`SSR_CTRL_OVR_EN] ? sCtrl_q[`SSR_CTRL_OVR_NS]
                                                : txnIncomingSecurityAttribute;
        end else if (entBypass || !entStage1) begin
            txNs = entOverrideEn ? entOverrideNs : txnIncomingSecurityAttribute;
        end else begin
            txNs = walkFromSecure ? (descNs | tableLevelSecurityBit) : 1'b1;
        end
        if (txSec && sCtrl_q[`SSR_CTRL_GUARD] && txnInstrFetch && txNs)
            txAbort = 1'b1;
    end

    // registered result and stream table fetch
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            outValid                <= 1'b0;
            outAbort                <= 1'b0;
            outNonSecureAttribute   <= 1'b1;
            outRegimeTag            <= `SSR_REG_NS;
            outAsidValid            <= 1'b0;
            fetchValid              <= 1'b0;
            fetchSecureTable        <= 1'b0;
            fetchIndex              <= 8'h00;
            fetchNonSecureAttribute <= 1'b1;
        end else begin
            outValid                <= txnValid;
            outAbort                <= txAbort;
            outNonSecureAttribute   <= txNs;
            outRegimeTag            <= !txSec ? `SSR_REG_NS
                                     : (entRegimeEl3 ? `SSR_REG_EL3 : `SSR_REG_SEL1);
            outAsidValid            <= ~(txSec & entRegimeEl3);
            fetchValid              <= txnValid & txEn;
            fetchSecureTable        <= txSec;
            fetchIndex              <= txnStreamId;
            fetchNonSecureAttribute <= ~txSec;
        end
    end

    // context descriptor fetch attribute
    wire ctxSec = ctxSecureStream & secOk;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctxValid              <= 1'b0;
            ctxNonSecureAttribute <= 1'b1;
            ctxViaStage2          <= 1'b0;
        end else begin
            ctxValid              <= ctxReq;
            ctxNonSecureAttribute <= ~ctxSec;
            ctxViaStage2          <= ctxSec & s2En;
        end
    end

    // one instance per interface keeps their state apart
    ssr_iface_state uNs (
        .clk         (clk),
        .resetn      (resetn),
        .setBits     (nsSet),
        .clrBits     (nsClr),
        .irqEn       (nsIrqEn_q),
        .ifaceEn     (nsEn),
        .xlatReq     (xlatNsReq),
        .xlatNsIn    (1'b1),
        .status_q    (nsStatus),
        .irq         (irqNs),
        .xlatDone_q  (xlatNsDone),
        .xlatFault_q (xlatNsFault),
        .xlatNs_q    (xlatNsResultNs)
    );

    ssr_iface_state uS (
        .clk         (clk),
        .resetn      (resetn),
        .setBits     (sSet),
        .clrBits     (sClr),
        .irqEn       (sIrqEn_q),
        .ifaceEn     (sEn),
        .xlatReq     (xlatSReq & secOk),
        .xlatNsIn    (xlatSNsIn),
        .status_q    (sStatus),
        .irq         (irqS),
        .xlatDone_q  (xlatSDone),
        .xlatFault_q (xlatSFault),
        .xlatNs_q    (xlatSResultNs)
    );
endmodule

// *** common/ssr_regs.vh ***
`ifndef SSR_REGS_VH
`define SSR_REGS_VH
// register byte offsets
`define SSR_NS_CTRL       8'h00
`define SSR_NS_IRQEN      8'h04
`define SSR_NS_STATUS     8'h08
`define SSR_S_CTRL        8'h10
`define SSR_S_IRQEN       8'h14
`define SSR_S_STATUS      8'h18
`define SSR_INFO          8'h20
// control fields (both interfaces)
`define SSR_CTRL_EN       0
`define SSR_CTRL_ABORT    1
// secure-only control fields
`define SSR_CTRL_OVR_EN   2
`define SSR_CTRL_OVR_NS   3
`define SSR_CTRL_GUARD    4
`define SSR_CTRL_S2EN     5
`define SSR_NS_CTRL_W     2
`define SSR_S_CTRL_W      6
// interrupt enable fields
`define SSR_IRQ_EVT       0
`define SSR_IRQ_ERR       1
// status fields, write one to clear
`define SSR_ST_CMDERR     0
`define SSR_ST_QABORT     1
`define SSR_ST_OVFL       2
`define SSR_ST_EVTPEND    3
`define SSR_ST_W          4
`define SSR_ST_ERRMASK    4'h7
// reset values
`define SSR_CTRL_RST      6'h00
`define SSR_IRQEN_RST     2'h0
`define SSR_ST_RST        4'h0
// translation regime tag codes
`define SSR_REG_NS        2'h0
`define SSR_REG_SEL1      2'h1
`define SSR_REG_EL3       2'h2
`endif

// *** dv/ssr_client_model.sv ***
`timescale 1ns/1ps
// client device: one transaction per cycle while go is high
module ssr_client_model (
    input  wire logic        clk,
    input  wire logic        go,
    input  wire logic [10:0] req,
    output logic             txnValid,
    output logic [7:0]       txnStreamId,
    output logic             txnInstrFetch,
    output logic             txnIncomingSecurityAttribute,
    output logic             txnSecureStreamFlag
);
    logic [10:0] idle = 11'h5a5;
    // released lines toggle so a stale value never passes for a request
    always @(posedge clk) idle <= ~idle;
    // flag 1 names a secure stream; the client picks its own attribute
    assign txnValid = go;
    assign {txnStreamId, txnInstrFetch, txnIncomingSecurityAttribute, txnSecureStreamFlag} =
        go ? req : idle;
endmodule

// *** dv/ssr_security_route_chk.sv ***
`timescale 1ns/1ps
// routing checks tied to the client, event and command inputs
module ssr_security_route_chk (
    input wire       clk,
    input wire       resetn,
    input wire       txnValid,
    input wire [7:0] txnStreamId,
    input wire       txnSecureStreamFlag,
    input wire       outValid,
    input wire       outNonSecureAttribute,
    input wire       fetchValid,
    input wire       fetchSecureTable,
    input wire [7:0] fetchIndex,
    input wire       fetchNonSecureAttribute,
    input wire       ctxReq,
    input wire       ctxSecureStream,
    input wire       ctxValid,
    input wire       ctxNonSecureAttribute,
    input wire       evtValid,
    input wire       evtSecureStream,
    input wire       evtNsFull,
    input wire       evtSFull,
    input wire       evtNsWrite,
    input wire       evtSWrite,
    input wire       cmdNsValid,
    input wire [7:0] cmdNsStreamId,
    input wire       cmdSValid,
    input wire       cmdSSecureStreamFlag,
    input wire       cmdOutValid,
    input wire [7:0] cmdOutStreamId,
    input wire       cmdOutSecureTarget,
    input wire       cmdOutNonSecureAttribute
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // events land only in the queue of their own side
    a_evt_secure_q: assert property (
        evtValid && evtSecureStream && !evtSFull |=> evtSWrite && !evtNsWrite)
        else $error("secure event misrouted");
    a_evt_nonsec_q: assert property (
        evtValid && !evtSecureStream && !evtNsFull |=> evtNsWrite && !evtSWrite)
        else $error("non-secure event misrouted");
    a_evt_full_stop: assert property (
        evtValid && evtSecureStream && evtSFull |=> !evtSWrite && !evtNsWrite)
        else $error("full secure queue still written");
    // commands keep to the streams their queue may touch
    a_nscmd_scope: assert property (
        cmdNsValid && !cmdSValid |=> cmdOutValid && !cmdOutSecureTarget
        && cmdOutNonSecureAttribute && cmdOutStreamId == $past(cmdNsStreamId))
        else $error("non-secure command escaped its streams");
    a_scmd_flag: assert property (
        cmdSValid |=> cmdOutValid && !cmdOutNonSecureAttribute
        && cmdOutSecureTarget == $past(cmdSSecureStreamFlag))
        else $error("secure command flag ignored");
    // stream N reads entry N of its own table, secure table with secure access
    a_fetch_entry: assert property (
        fetchValid |-> outValid && $past(txnValid) && fetchIndex == $past(txnStreamId)
        && fetchSecureTable == $past(txnSecureStreamFlag)
        && fetchNonSecureAttribute != fetchSecureTable)
        else $error("stream table fetch wrong");
    a_ns_attr_one: assert property (
        txnValid && !txnSecureStreamFlag |=> outValid && outNonSecureAttribute)
        else $error("non-secure stream made secure access");
    a_cd_attr: assert property (
        ctxReq |=> ctxValid && ctxNonSecureAttribute == !$past(ctxSecureStream))
        else $error("context fetch attribute wrong");
endmodule

bind ssr_security_route ssr_security_route_chk ssr_security_route_chk_inst (.*);

// *** dv/ssr_security_route_bench.sv ***
`timescale 1ns/1ps
`include "ssr_regs.vh"
module ssr_security_route_bench;
    logic        clk = 0, resetn = 0, go = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [3:0]  wb_sel_i = 4'h1;
    logic [7:0]  wb_adr_i = 8'h00, evtCode = 8'h00, cmdNsStreamId = 8'h00, cmdSStreamId = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000, x = 32'h0000_005f, rd, cyc = 32'h0000_0000;
    logic [10:0] req = 11'h000;
    logic [1:0]  nC = 2'h0, outRegimeTag;
    logic [5:0]  sC = 6'h00;
    logic        entBypass = 0, entOverrideEn = 0, entOverrideNs = 0, entStage1 = 0;
    logic        entRegimeEl3 = 0, walkFromSecure = 0, descNs = 0, tableLevelSecurityBit = 0;
    logic        ctxReq = 0, ctxSecureStream = 0, evtValid = 0, evtSecureStream = 0;
    logic        evtNsFull = 0, evtSFull = 0, cmdNsValid = 0, cmdSValid = 0, cmdNsError = 0;
    logic        cmdSSecureStreamFlag = 0, cmdSError = 0, queueNsAbort = 0, queueSAbort = 0;
    logic        xlatNsReq = 0, xlatSReq = 0, xlatSNsIn = 0;
    logic [7:0]  e, evtData, fetchIndex, cmdOutStreamId, txnStreamId;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, txnValid, txnSecureStreamFlag, txnIncomingSecurityAttribute;
    logic        txnInstrFetch, outValid, outAbort, outNonSecureAttribute, outAsidValid;
    logic        fetchValid, fetchSecureTable, fetchNonSecureAttribute, ctxValid, ctxViaStage2;
    logic        ctxNonSecureAttribute, evtNsWrite, evtSWrite, evtNonSecureAttribute;
    logic        cmdOutValid, cmdOutSecureTarget, cmdOutNonSecureAttribute, xlatNsDone;
    logic        xlatNsFault, xlatNsResultNs, xlatSDone, xlatSFault, xlatSResultNs, irqNs, irqS;
    logic [7:0]  regA[8] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h20, 8'h30};
    logic [7:0]  expQ[$];
    int          error_cnt = 0, samples_checked = 0;

    ssr_security_route ssr_security_route_inst (.*);
    ssr_client_model ssr_client_model_inst (.*);

    always #10 clk = ~clk;

    function automatic logic [31:0] rnd();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // one classic cycle; request held until ack is seen at an edge
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk); while (wb_ack_o !== 1'h1);
        rd = wb_dat_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
        @(posedge clk);
    endtask

    // sample edge, drop every strobe, look once outputs settle
    task automatic strobe();
        @(posedge clk);
        {evtValid, cmdNsValid, cmdSValid, ctxReq, xlatNsReq, xlatSReq} <= 6'h00;
        {cmdNsError, queueSAbort} <= 2'h0;
        @(negedge clk);
    endtask

    // note the expected outcome, then present one transaction
    task automatic txn(input logic [31:0] r);
        logic s, ns, ab;
        s = r[0];
        ab = 0;
        if (!s) begin
            ns = 1;
            ab = !nC[0] & nC[1];
        end else if (!sC[0]) begin
            ab = sC[1];
            ns = sC[2] ? sC[3] : r[1];
        end else if (r[18] | !r[15]) begin
            ns = r[17] ? r[16] : r[1];
        end else begin
            ns = r[13] ? (r[12] | r[11]) : 1'h1;
        end
        if (s & sC[4] & r[2] & ns) ab = 1;
        // non-secure streams carry the plain tag with an asid; secure ones carry an asid except at EL3
        expQ.push_back({1'h1, ab, ns, s ? sC[0] : nC[0], s, s ? {r[14], !r[14], !r[14]} : 3'h1});
        go <= 1;
        req <= r[10:0];
        {entBypass, entOverrideEn, entOverrideNs, entStage1, entRegimeEl3, walkFromSecure,
         descNs, tableLevelSecurityBit} <= r[18:11];
        @(posedge clk);
    endtask

    // results are matched in order; the cycle count cuts a hang short
    always @(posedge clk) begin
        cyc <= cyc + 32'h0000_0001;
        if (cyc == 32'h0000_0bb8) begin
            error_cnt++;
            complete_run();
        end
        if (outValid === 1'h1) begin
            e = expQ.pop_front();
            check({outValid, outAbort, outNonSecureAttribute, fetchValid,
                   fetchSecureTable, outRegimeTag, outAsidValid}, e);
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1;
        foreach (regA[i]) begin
            wb(0, regA[i], 32'h0000_0000);
            check(rd, {31'h0000_0000, i == 6});
        end
        $display("reset values done");
        // random controls per side, then a burst of back-to-back transactions
        repeat (10) begin
            x = rnd();
            nC = x[1:0];
            sC = x[7:2];
            wb(1, `SSR_NS_CTRL, {30'h0000_0000, nC});
            wb(1, `SSR_S_CTRL, {26'h000_0000, sC});
            wb(0, `SSR_S_CTRL, 32'h0000_0000);
            check(rd, {26'h000_0000, sC});
            repeat (12) txn(rnd());
            go <= 0;
            repeat (3) @(posedge clk);
        end
        $display("transactions done");
        // each side delivers while the other is full, then overflows on its own
        for (int k = 0; k < 4; k++) begin
            x = rnd();
            {evtValid, evtSecureStream, evtNsFull, evtSFull} <=
                {1'h1, k[0], k[0] ^ k[1], !(k[0] ^ k[1])};
            evtCode <= x[7:0];
            strobe();
            check({evtSWrite, evtNsWrite}, {k[0] & !k[1], !k[0] & !k[1]});
            if (!k[1]) check({evtNonSecureAttribute, evtData}, {!k[0], x[7:0]});
            @(posedge clk);
        end
        cmdNsError <= 1;
        queueSAbort <= 1;
        strobe();
        @(posedge clk);
        wb(0, `SSR_NS_STATUS, 32'h0000_0000);
        check(rd, 32'h0000_000d);
        wb(0, `SSR_S_STATUS, 32'h0000_0000);
        check(rd, 32'h0000_000e);
        wb(1, `SSR_NS_IRQEN, 32'h0000_0002);
        check({irqNs, irqS}, 2'h2);
        wb(1, `SSR_S_IRQEN, 32'h0000_0001);
        check({irqNs, irqS}, 2'h3);
        wb(1, `SSR_NS_STATUS, 32'h0000_000f);
        check({irqNs, irqS}, 2'h1);
        $display("events and errors done");
        // one queue at a time; secure commands name either side
        for (int k = 0; k < 3; k++) begin
            x = rnd();
            {cmdNsValid, cmdSValid, cmdSSecureStreamFlag} <= {k == 0, k != 0, k == 2};
            cmdNsStreamId <= x[7:0];
            cmdSStreamId <= x[7:0];
            strobe();
            check({cmdOutValid, cmdOutSecureTarget,
                   cmdOutNonSecureAttribute, cmdOutStreamId}, {1'h1, k == 2, k == 0, x[7:0]});
            @(posedge clk);
        end
        // context fetches with secure stage 2 off, then on
        for (int k = 0; k < 4; k++) begin
            if (!k[0]) wb(1, `SSR_S_CTRL, k == 2 ? 32'h0000_0020 : 32'h0000_0000);
            {ctxReq, ctxSecureStream} <= {1'h1, k[0]};
            strobe();
            check({ctxValid, ctxNonSecureAttribute, ctxViaStage2}, {1'h1, !k[0], k[0] & k[1]});
            @(posedge clk);
        end
        // request ports answer apart: secure side disabled, non-secure enabled
        wb(1, `SSR_NS_CTRL, 32'h0000_0001);
        {xlatNsReq, xlatSReq} <= 2'h3;
        strobe();
        check({xlatNsDone, xlatNsFault, xlatNsResultNs,
               xlatSDone, xlatSFault, xlatSResultNs}, 6'h2e);
        $display("commands, fetches and ports done");
        repeat (3) @(posedge clk);
        check(32'(expQ.size()), 32'h0000_0000);
        complete_run();
    end
endmodule
